// ### src/pdwc_portwake.v
// Per-pin Port A falling-edge wake latches.
// Assumes the pins and enables are steady levels; latches run on the pin edge.
`timescale 1ns/1ps
module pdwc_portwake (
	input  wire       arm,
	input  wire       clear,
	input  wire [7:0] pin,
	input  wire [7:0] enable,
	output wire       wake
);
	wire [7:0] hit;
	// ----------------------------------------
	// Edge latches, one per pin
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_pin
			reg hit_q;
			always @(negedge pin[i] or posedge clear) begin
				if (clear) begin
					hit_q <= 1'b0;
				end else if (arm && enable[i]) begin
					hit_q <= 1'b1;
				end
			end
			assign hit[i] = hit_q;
		end
	endgenerate
	assign wake = |hit;
endmodule // pdwc_portwake

// ### src/pdwc_regs.vh
// Constants for the power-down and wake-up controller.
// Assumes inclusion by bare name from the design files.
`ifndef PDWC_REGS_VH
`define PDWC_REGS_VH
// ----------------------------------------
// Register map
// ----------------------------------------
`define PDWC_ADDR_W        4
`define PDWC_REG_CTRL      4'h0
`define PDWC_REG_STATUS    4'h1
`define PDWC_REG_WAKEEN    4'h2
`define PDWC_REG_CAUSE     4'h3
`define PDWC_REG_WDTCNT    4'h4
// ----------------------------------------
// Control fields
// ----------------------------------------
`define PDWC_CTRL_RC_MODE  0
`define PDWC_CTRL_WDT_EN   1
`define PDWC_CTRL_WDT_OSC  2
`define PDWC_CTRL_WDOSC_EN 3
`define PDWC_CTRL_RTC_EN   4
`define PDWC_CTRL_RESET    8'h0a
// ----------------------------------------
// Status fields
// ----------------------------------------
`define PDWC_ST_PDF        0
`define PDWC_ST_TO         1
`define PDWC_ST_HALTED     2
`define PDWC_ST_WAKING     3
`define PDWC_WAKEEN_RESET  8'h00
// ----------------------------------------
// Wake causes
// ----------------------------------------
`define PDWC_CAUSE_NONE    3'h0
`define PDWC_CAUSE_PORTA   3'h1
`define PDWC_CAUSE_INT     3'h2
`define PDWC_CAUSE_WDT     3'h3
// ----------------------------------------
// Timing
// ----------------------------------------
`define PDWC_WAKE_CYCLES   1024
`define PDWC_WAKE_CNT_W    11
`define PDWC_WDT_BITS      16
`endif

// ### src/pdwc_top.v
// Power-down and wake-up controller: halt entry, clock gating, flags, wake.
// Assumes HALT_EXEC, WATCHDOG_CLEAR_INSTRUCTION_EXEC and interrupt inputs are one-cycle pulses.
`timescale 1ns/1ps
`include "pdwc_regs.vh"
module pdwc_top (
	input  wire                   CLK,
	input  wire                   RESET,
	input  wire                   POR,
	input  wire                   EXT_RESET_PIN_N,
	input  wire                   HALT_EXEC,
	input  wire                   WATCHDOG_CLEAR_INSTRUCTION_EXEC,
	input  wire [7:0]             PORTA_PIN,
	input  wire                   INT_REQ,
	input  wire                   INT_ENABLE,
	input  wire                   STACK_FULL,
	input  wire                   WDT_OSC_TICK,
	input  wire [7:0]             CONVERTER_CONTROL_REG,
	input  wire [`PDWC_ADDR_W-1:0] ADDR,
	input  wire [7:0]             WDATA,
	input  wire                   WR,
	input  wire                   RD,
	output reg  [7:0]             RDATA,
	output wire                   SYS_CLK_RUN,
	output wire                   CPU_STALL,
	output wire                   RTC_OSC_RUN,
	output wire                   WDT_OSC_RUN,
	output wire                   XTAL_OSC_EN,
	output wire                   RC_OSC_EN,
	output wire                   OSC_OUTPUT_PIN_O,
	output wire                   OSC_OUTPUT_PIN_OE_N,
	output wire                   CONVERTER_POWER,
	output wire                   SYS_RESET,
	output reg                    PC_SP_RESET,
	output reg                    INT_SERVICE,
	output reg                    RESUME_NEXT,
	output wire                   POWER_DOWN_FLAG,
	output wire                   WATCHDOG_TIMEOUT_FLAG
);
	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam ST_RUN    = 2'd0;
	localparam ST_HALT   = 2'd1;
	localparam ST_WAKE   = 2'd2;
	localparam integer WAKE_LAST_I = `PDWC_WAKE_CYCLES - 1;
	localparam [`PDWC_WAKE_CNT_W-1:0] WAKE_LAST = WAKE_LAST_I[`PDWC_WAKE_CNT_W-1:0];

	reg [1:0]                   state_q;
	reg [1:0]                   state_d;
	reg [`PDWC_WAKE_CNT_W-1:0]  wcnt_q;
	reg [2:0]                   cause_q;
	reg                         pdf_q;
	reg                         to_q;
	reg                         int_pre_q;
	reg [7:0]                   ctrl_q;
	reg [7:0]                   wakeen_q;
	reg [1:0]                   div_q;
	reg                         clkout_q;
	reg                         pin_reset_seen_q;
	reg                         rd_valid_unused;

	wire rst_pin      = ~EXT_RESET_PIN_N;
	wire full_reset   = RESET | rst_pin;
	wire halted       = (state_q == ST_HALT);
	wire waking       = (state_q == ST_WAKE);
	wire wdt_sys_clk  = ~ctrl_q[`PDWC_CTRL_WDT_OSC];
	wire wdt_en       = ctrl_q[`PDWC_CTRL_WDT_EN];
	wire port_wake;
	wire wdt_ovf;
	wire [`PDWC_WDT_BITS-1:0] wdt_count;
	wire wdt_tick;
	wire wdt_clear;
	wire halt_enter   = (state_q == ST_RUN) & HALT_EXEC;
	wire int_wake     = halted & INT_REQ & ~int_pre_q;
	wire wdt_wake     = halted & wdt_ovf;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_RUN: begin
				if (halt_enter) begin
					state_d = ST_HALT;
				end
			end
			ST_HALT: begin
				if (port_wake | int_wake | wdt_wake) begin
					state_d = ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (wcnt_q == WAKE_LAST) begin
					state_d = ST_RUN;
				end
			end
			default: begin
				state_d = ST_RUN;
			end
		endcase
	end

	always @(posedge CLK or posedge full_reset) begin
		if (full_reset) begin
			state_q   <= ST_RUN;
			wcnt_q    <= {`PDWC_WAKE_CNT_W{1'b0}};
			cause_q   <= `PDWC_CAUSE_NONE;
			int_pre_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (state_q != ST_WAKE) begin
				wcnt_q <= {`PDWC_WAKE_CNT_W{1'b0}};
			end else begin
				wcnt_q <= wcnt_q + 1'b1;
			end
			if (halt_enter) begin
				int_pre_q <= INT_REQ;
				cause_q   <= `PDWC_CAUSE_NONE;
			end else if (halted && state_d == ST_WAKE) begin
				if (wdt_wake) begin
					cause_q <= `PDWC_CAUSE_WDT;
				end else if (int_wake) begin
					cause_q <= `PDWC_CAUSE_INT;
				end else begin
					cause_q <= `PDWC_CAUSE_PORTA;
				end
			end
		end
	end

	// ----------------------------------------
	// Resume actions at end of wake delay
	// ----------------------------------------
	wire wake_done = waking & (wcnt_q == WAKE_LAST);
	always @(posedge CLK or posedge full_reset) begin
		if (full_reset) begin
			PC_SP_RESET <= 1'b0;
			INT_SERVICE <= 1'b0;
			RESUME_NEXT <= 1'b0;
		end else begin
			PC_SP_RESET <= wake_done & (cause_q == `PDWC_CAUSE_WDT);
			INT_SERVICE <= wake_done & (cause_q == `PDWC_CAUSE_INT) & INT_ENABLE & ~STACK_FULL;
			RESUME_NEXT <= wake_done & ((cause_q == `PDWC_CAUSE_PORTA) |
				((cause_q == `PDWC_CAUSE_INT) & ~(INT_ENABLE & ~STACK_FULL)));
		end
	end

	// ----------------------------------------
	// Reset-cause flags
	// ----------------------------------------
	always @(posedge CLK or posedge POR) begin
		if (POR) begin
			pdf_q <= 1'b0;
			to_q  <= 1'b0;
		end else begin
			if (halt_enter) begin
				pdf_q <= 1'b1;
				to_q  <= 1'b0;
			end else if (wdt_ovf) begin
				to_q  <= 1'b1;
			end else if (WATCHDOG_CLEAR_INSTRUCTION_EXEC && !halted) begin
				pdf_q <= 1'b0;
				to_q  <= 1'b0;
			end else if (pin_reset_seen_q && !halted) begin
				to_q  <= 1'b0;
			end
		end
	end

	// Pin reset in halt keeps POWER_DOWN_FLAG; TO cleared at the first clock edge after the pin goes low
	always @(posedge CLK or posedge rst_pin) begin
		if (rst_pin) begin
			pin_reset_seen_q <= 1'b1;
		end else begin
			pin_reset_seen_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	assign wdt_clear = halt_enter | (WATCHDOG_CLEAR_INSTRUCTION_EXEC & ~halted);
	assign wdt_tick  = wdt_en & (wdt_sys_clk ? (~halted & (div_q == 2'd3)) :
		(WDT_OSC_RUN & WDT_OSC_TICK));

	pdwc_wdt u_wdt (
		.clk      (CLK),
		.reset    (full_reset),
		.tick     (wdt_tick),
		.clear    (wdt_clear),
		.overflow (wdt_ovf),
		.count    (wdt_count)
	);

	pdwc_portwake u_pw (
		.arm    (halted),
		.clear  (~halted | full_reset),
		.pin    (PORTA_PIN),
		.enable (wakeen_q),
		.wake   (port_wake)
	);

	// ----------------------------------------
	// Clocks and pins
	// ----------------------------------------
	always @(posedge CLK or posedge full_reset) begin
		if (full_reset) begin
			div_q    <= 2'd0;
			clkout_q <= 1'b0;
		end else begin
			div_q <= div_q + 1'b1;
			if (div_q[0]) begin
				clkout_q <= ~clkout_q;
			end
		end
	end

	assign SYS_CLK_RUN         = ~halted;
	assign CPU_STALL           = halted | waking;
	assign RTC_OSC_RUN         = ctrl_q[`PDWC_CTRL_RTC_EN];
	assign WDT_OSC_RUN         = ctrl_q[`PDWC_CTRL_WDOSC_EN];
	assign RC_OSC_EN           = ctrl_q[`PDWC_CTRL_RC_MODE] & ~halted;
	assign XTAL_OSC_EN         = ~ctrl_q[`PDWC_CTRL_RC_MODE] & ~halted;
	assign OSC_OUTPUT_PIN_O    = 1'b0;
	assign OSC_OUTPUT_PIN_OE_N = ~(ctrl_q[`PDWC_CTRL_RC_MODE] & ~clkout_q);
	assign CONVERTER_POWER     = |CONVERTER_CONTROL_REG[2:0];
	assign SYS_RESET           = full_reset;
	assign POWER_DOWN_FLAG       = pdf_q;
	assign WATCHDOG_TIMEOUT_FLAG = to_q;

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	// Pin reset is a full system reset, registers included
	always @(posedge CLK or posedge full_reset) begin
		if (full_reset) begin
			ctrl_q   <= `PDWC_CTRL_RESET;
			wakeen_q <= `PDWC_WAKEEN_RESET;
		end else if (WR && !halted) begin
			if (ADDR == `PDWC_REG_CTRL) begin
				ctrl_q <= WDATA;
			end else if (ADDR == `PDWC_REG_WAKEEN) begin
				wakeen_q <= WDATA;
			end
		end
	end

	always @(posedge CLK or posedge full_reset) begin
		if (full_reset) begin
			RDATA           <= 8'h00;
			rd_valid_unused <= 1'b0;
		end else begin
			rd_valid_unused <= RD;
			RDATA           <= 8'h00;
			if (RD) begin
				if (ADDR == `PDWC_REG_CTRL) begin
					RDATA <= ctrl_q;
				end else if (ADDR == `PDWC_REG_STATUS) begin
					RDATA <= {4'h0, waking, halted, to_q, pdf_q};
				end else if (ADDR == `PDWC_REG_WAKEEN) begin
					RDATA <= wakeen_q;
				end else if (ADDR == `PDWC_REG_CAUSE) begin
					RDATA <= {5'h00, cause_q};
				end else if (ADDR == `PDWC_REG_WDTCNT) begin
					RDATA <= wdt_count[`PDWC_WDT_BITS-1:`PDWC_WDT_BITS-8];
				end
			end
		end
	end
endmodule // pdwc_top

// ### src/pdwc_wdt.v
// Watchdog counter with clear and overflow pulse.
// Assumes tick is a one-cycle enable from the selected watchdog clock source.
`timescale 1ns/1ps
`include "pdwc_regs.vh"
module pdwc_wdt (
	input  wire                      clk,
	input  wire                      reset,
	input  wire                      tick,
	input  wire                      clear,
	output reg                       overflow,
	output wire [`PDWC_WDT_BITS-1:0] count
);
	reg [`PDWC_WDT_BITS-1:0] cnt_q;
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_q    <= {`PDWC_WDT_BITS{1'b0}};
			overflow <= 1'b0;
		end else begin
			overflow <= 1'b0;
			if (clear) begin
				cnt_q <= {`PDWC_WDT_BITS{1'b0}};
			end else if (tick) begin
				cnt_q <= cnt_q + 1'b1;
				if (&cnt_q) begin
					overflow <= 1'b1;
				end
			end
		end
	end
	assign count = cnt_q;
endmodule // pdwc_wdt

// ### test/pdwc_chk_sva.sv
// Checker on the top ports of the power-down and wake-up controller.
// Assumes one clock domain; bound to every instance of pdwc_top below.
`timescale 1ns/1ps
module pdwc_chk (
	input wire       CLK,
	input wire       RESET,
	input wire       POR,
	input wire       EXT_RESET_PIN_N,
	input wire       HALT_EXEC,
	input wire       WATCHDOG_CLEAR_INSTRUCTION_EXEC,
	input wire [7:0] CONVERTER_CONTROL_REG,
	input wire       SYS_CLK_RUN,
	input wire       CPU_STALL,
	input wire       XTAL_OSC_EN,
	input wire       RC_OSC_EN,
	input wire       OSC_OUTPUT_PIN_O,
	input wire       OSC_OUTPUT_PIN_OE_N,
	input wire       CONVERTER_POWER,
	input wire       SYS_RESET,
	input wire       PC_SP_RESET,
	input wire       INT_SERVICE,
	input wire       RESUME_NEXT,
	input wire       POWER_DOWN_FLAG,
	input wire       WATCHDOG_TIMEOUT_FLAG
);
	// ----------------------------------------
	// Wake wait counter
	// ----------------------------------------
	reg  [10:0] wake_cnt_q;
	wire        run_halt = HALT_EXEC && !CPU_STALL && EXT_RESET_PIN_N && !POR;
	always @(posedge CLK or posedge RESET) begin
		if (RESET)
			wake_cnt_q <= 11'h000;
		else if (SYS_CLK_RUN && CPU_STALL)
			wake_cnt_q <= wake_cnt_q + 11'h001;
		else
			wake_cnt_q <= 11'h000;
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	halt_flags_a: assert property (run_halt |=> POWER_DOWN_FLAG && !WATCHDOG_TIMEOUT_FLAG)
		else $error("halt entry flags wrong");
	halt_clock_a: assert property (run_halt |=> !SYS_CLK_RUN && !XTAL_OSC_EN && !RC_OSC_EN)
		else $error("clock still running in halt");
	halt_cause_a: assert property ($fell(SYS_CLK_RUN) |-> $past(HALT_EXEC))
		else $error("halt without instruction");
	wake_delay_a: assert property ($fell(CPU_STALL) && EXT_RESET_PIN_N |-> wake_cnt_q == 11'd1024)
		else $error("wake wait not 1024 cycles");
	por_clear_a: assert property (POR |-> !POWER_DOWN_FLAG && !WATCHDOG_TIMEOUT_FLAG)
		else $error("power-on left a flag set");
	wdt_clear_a: assert property (WATCHDOG_CLEAR_INSTRUCTION_EXEC && !run_halt && !POR |=> !POWER_DOWN_FLAG)
		else $error("watchdog clear kept power-down flag");
	clkout_div_a: assert property (RC_OSC_EN [*5] |-> !OSC_OUTPUT_PIN_O &&
		OSC_OUTPUT_PIN_OE_N != $past(OSC_OUTPUT_PIN_OE_N, 2))
		else $error("clock output not divided by four");
	adc_power_a: assert property (|CONVERTER_CONTROL_REG[2:0] |-> CONVERTER_POWER)
		else $error("converter unpowered with analog input");
	pin_reset_a: assert property (!EXT_RESET_PIN_N |-> SYS_RESET)
		else $error("pin low without system reset");
	osc_choice_a: assert property (SYS_CLK_RUN |-> XTAL_OSC_EN != RC_OSC_EN)
		else $error("not exactly one clock source");
	wdt_wake_a: assert property (PC_SP_RESET |-> WATCHDOG_TIMEOUT_FLAG && POWER_DOWN_FLAG)
		else $error("watchdog wake flags wrong");
	resume_one_a: assert property ($onehot0({RESUME_NEXT, INT_SERVICE, PC_SP_RESET}))
		else $error("more than one resume pulse");
endmodule // pdwc_chk

bind pdwc_top pdwc_chk chk_u (.CLK, .RESET, .POR, .EXT_RESET_PIN_N, .HALT_EXEC, .WATCHDOG_CLEAR_INSTRUCTION_EXEC,
	.CONVERTER_CONTROL_REG, .SYS_CLK_RUN, .CPU_STALL, .XTAL_OSC_EN, .RC_OSC_EN, .OSC_OUTPUT_PIN_O,
	.OSC_OUTPUT_PIN_OE_N, .CONVERTER_POWER, .SYS_RESET, .PC_SP_RESET, .INT_SERVICE, .RESUME_NEXT,
	.POWER_DOWN_FLAG, .WATCHDOG_TIMEOUT_FLAG);

// ### test/pdwc_far_model.sv
// Far-side model: Port A wake pins, external reset pin, interrupt line.
// Assumes the bench calls its tasks; changes land just after a rising edge.
`timescale 1ns/1ps
module pdwc_far_model (
	input  wire       clk,
	output reg  [7:0] pa_pin,
	output reg        rst_pin_n,
	output reg        irq
);
	initial begin
		pa_pin    = 8'hff; // Pull-ups hold idle pins high
		rst_pin_n = 1'b1;
		irq       = 1'b0;
	end
	task fall(input int i);
		@(posedge clk) pa_pin <= pa_pin & ~(8'h01 << i);
	endtask
	task rise;
		@(posedge clk) pa_pin <= 8'hff;
	endtask
	task set_irq(input logic v);
		@(posedge clk) irq <= v;
	endtask
	task rst_pulse(input int n);
		@(posedge clk) rst_pin_n <= 1'b0;
		repeat (n) @(posedge clk);
		rst_pin_n <= 1'b1;
	endtask
endmodule // pdwc_far_model

// ### test/tb_top.sv
// Bench for the power-down and wake-up controller.
// Assumes the checker binds itself and the far-side model drives the pins.
`timescale 1ns/1ps
`include "pdwc_regs.vh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
	$display("unexpected at %0t: %h vs %h", $time, a, b); end end
module tb_top;
	logic                    CLK, RESET, POR, HALT_EXEC, WATCHDOG_CLEAR_INSTRUCTION_EXEC;
	logic                    INT_ENABLE, STACK_FULL, WDT_OSC_TICK, WR, RD;
	logic [7:0]              CONVERTER_CONTROL_REG, WDATA;
	logic [`PDWC_ADDR_W-1:0] ADDR;
	wire  [7:0]              RDATA, PORTA_PIN;
	wire                     SYS_CLK_RUN, CPU_STALL, RTC_OSC_RUN, WDT_OSC_RUN, XTAL_OSC_EN, RC_OSC_EN;
	wire                     OSC_OUTPUT_PIN_O, OSC_OUTPUT_PIN_OE_N, CONVERTER_POWER, SYS_RESET, PC_SP_RESET;
	wire                     INT_SERVICE, RESUME_NEXT, POWER_DOWN_FLAG, WATCHDOG_TIMEOUT_FLAG, EXT_RESET_PIN_N, INT_REQ;
	int                      n_mismatch = 0, samples_checked = 0;
	always #25 CLK = ~CLK;
	pdwc_far_model far_u (.clk(CLK), .pa_pin(PORTA_PIN), .rst_pin_n(EXT_RESET_PIN_N), .irq(INT_REQ));
	pdwc_top dut_u (.CLK, .RESET, .POR, .EXT_RESET_PIN_N, .HALT_EXEC, .WATCHDOG_CLEAR_INSTRUCTION_EXEC, .PORTA_PIN, .INT_REQ,
		.INT_ENABLE, .STACK_FULL, .WDT_OSC_TICK, .CONVERTER_CONTROL_REG, .ADDR, .WDATA, .WR, .RD, .RDATA,
		.SYS_CLK_RUN, .CPU_STALL, .RTC_OSC_RUN, .WDT_OSC_RUN, .XTAL_OSC_EN, .RC_OSC_EN, .OSC_OUTPUT_PIN_O,
		.OSC_OUTPUT_PIN_OE_N, .CONVERTER_POWER, .SYS_RESET, .PC_SP_RESET, .INT_SERVICE, .RESUME_NEXT,
		.POWER_DOWN_FLAG, .WATCHDOG_TIMEOUT_FLAG);
	// ----------------------------------------
	// Bus and sequencing helpers
	// ----------------------------------------
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge CLK) begin ADDR <= a; WDATA <= d; WR <= 1'b1; end
		@(posedge CLK) WR <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge CLK) begin ADDR <= a; RD <= 1'b1; end
		@(posedge CLK) RD <= 1'b0;
		#1 `CHK(RDATA, e)
	endtask
	task pulse_halt;
		@(posedge CLK) HALT_EXEC <= 1'b1;
		@(posedge CLK) HALT_EXEC <= 1'b0;
		#1;
	endtask
	task wait_pulse(output int n);
		n = 0;
		while (!(RESUME_NEXT | INT_SERVICE | PC_SP_RESET) && n < 70000) begin
			@(posedge CLK);
			#1 n++;
		end
		if (n >= 70000)
			n_mismatch++;
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_regs;
		rd(`PDWC_REG_CTRL, 8'h0a);
		rd(4'hf, 8'h00);
		wr(`PDWC_REG_WAKEEN, 8'h01);
		rd(`PDWC_REG_WAKEEN, 8'h01);
	endtask
	task t_porta;
		int n;
		pulse_halt;
		`CHK({SYS_CLK_RUN, POWER_DOWN_FLAG, WATCHDOG_TIMEOUT_FLAG, WDT_OSC_RUN}, 4'b0101)
		far_u.fall(1);
		repeat (20) @(posedge CLK);
		#1 `CHK(CPU_STALL, 1'b1)
		far_u.fall(0);
		wait_pulse(n);
		`CHK({RESUME_NEXT, n inside {[1024:1028]}}, 2'b11)
		far_u.rise;
		rd(`PDWC_REG_CAUSE, 8'h01);
		rd(`PDWC_REG_WAKEEN, 8'h01);
	endtask
	task t_int;
		int n;
		far_u.set_irq(1'b1);
		pulse_halt;
		repeat (40) @(posedge CLK);
		#1 `CHK(SYS_CLK_RUN, 1'b0)
		far_u.set_irq(1'b0);
		far_u.fall(0);
		wait_pulse(n);
		far_u.rise;
		for (int i = 0; i < 3; i++) begin
			@(posedge CLK) begin INT_ENABLE <= (i != 1); STACK_FULL <= (i == 2); end
			pulse_halt;
			far_u.set_irq(1'b1);
			wait_pulse(n);
			`CHK({INT_SERVICE, RESUME_NEXT}, (i == 0) ? 2'b10 : 2'b01)
			far_u.set_irq(1'b0);
		end
		rd(`PDWC_REG_CAUSE, 8'h02);
	endtask
	task t_pin;
		pulse_halt;
		far_u.rst_pulse(3);
		repeat (2) @(posedge CLK);
		#1 `CHK({POWER_DOWN_FLAG, WATCHDOG_TIMEOUT_FLAG}, 2'b10)
		repeat (1100) @(posedge CLK);
		rd(`PDWC_REG_WAKEEN, 8'h00);
	endtask
	task t_wdt;
		int n;
		wr(`PDWC_REG_CTRL, 8'h0e);
		pulse_halt;
		@(posedge CLK) WDT_OSC_TICK <= 1'b1;
		wait_pulse(n);
		`CHK({PC_SP_RESET, WATCHDOG_TIMEOUT_FLAG, POWER_DOWN_FLAG}, 3'b111)
		@(posedge CLK) WDT_OSC_TICK <= 1'b0;
		rd(`PDWC_REG_CAUSE, 8'h03);
	endtask
	task t_misc;
		int n;
		@(posedge CLK) WATCHDOG_CLEAR_INSTRUCTION_EXEC <= 1'b1;
		@(posedge CLK) WATCHDOG_CLEAR_INSTRUCTION_EXEC <= 1'b0;
		#1 `CHK(POWER_DOWN_FLAG, 1'b0)
		wr(`PDWC_REG_WAKEEN, 8'h01);
		wr(`PDWC_REG_CTRL, 8'h1b);
		@(posedge CLK) CONVERTER_CONTROL_REG <= 8'h01;
		repeat (8) @(posedge CLK);
		#1 `CHK({RC_OSC_EN, XTAL_OSC_EN, CONVERTER_POWER}, 3'b101)
		pulse_halt;
		`CHK({RTC_OSC_RUN, CONVERTER_POWER}, 2'b11)
		far_u.fall(0);
		wait_pulse(n);
		far_u.rise;
		@(posedge CLK) POR <= 1'b1;
		@(posedge CLK) POR <= 1'b0;
		#1 `CHK({POWER_DOWN_FLAG, WATCHDOG_TIMEOUT_FLAG}, 2'b00)
	endtask
	initial begin
		CLK = 1'b0;
		RESET = 1'b1;
		POR = 1'b0;
		HALT_EXEC = 1'b0;
		WATCHDOG_CLEAR_INSTRUCTION_EXEC = 1'b0;
		INT_ENABLE = 1'b0;
		STACK_FULL = 1'b0;
		WDT_OSC_TICK = 1'b0;
		WR = 1'b0;
		RD = 1'b0;
		CONVERTER_CONTROL_REG = 8'h00;
		WDATA = 8'h00;
		ADDR = 4'h0;
		repeat (3) @(posedge CLK);
		RESET <= 1'b0;
		t_regs;
		t_porta;
		t_int;
		t_pin;
		t_wdt;
		t_misc;
		print_verdict;
	end
	initial begin
		#8000000;
		n_mismatch++;
		print_verdict;
	end
endmodule // tb_top
